// *** design/drv_mode_consts.svh ***
`ifndef DRV_MODE_CONSTS_SVH
`define DRV_MODE_CONSTS_SVH

// ==========================================================
// channel layout
`define NUM_CH 8
`define PAIR_CH 4
`define STATUS_W 16
`define OVL_BIT 0
`define OT_BIT 1

// ==========================================================
// channel mode codes
`define MODE_STANDBY 2'h0
`define MODE_PARALLEL 2'h1
`define MODE_ON 2'h2
`define MODE_OFF 2'h3

// ==========================================================
// reset values
`define MODES_RESET 16'hFFFF
`define FAULTS_RESET 8'h00

// ==========================================================
// timing
`define CLK_PERIOD_NS 20
`define OVL_FILTER_NS 15000
`define OVL_FILTER_CYC ((`OVL_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVL_CNT_W 10

`endif

// *** design/drv_mode_pkg.sv ***
`include "drv_mode_consts.svh"

package drv_mode_pkg;

    typedef enum logic [1:0] {
        op_uvlo = 2'h0,
        op_low_iq = 2'h1,
        op_global_off = 2'h2,
        op_limp = 2'h3
    } op_state_type;

    // asynchronous pins, synchronised as one bundle
    typedef struct packed {
        logic enable;
        logic limp_home_input;
        logic logic_supply_ok;
        logic analog_supply_ok;
        logic [`PAIR_CH-1:0] par_in;
        logic [`NUM_CH-1:0] overcurrent;
        logic [`NUM_CH-1:0] overtemp;
    } pin_bundle_type;

    // one checked serial frame from the framer, same clock
    typedef struct packed {
        logic valid;
        logic frame_ok;
        logic [2*`NUM_CH-1:0] modes;
    } cmd_frame_type;

    typedef struct packed {
        pin_bundle_type sync1;
        pin_bundle_type sync2;
        pin_bundle_type prev;
        op_state_type state;
        logic [2*`NUM_CH-1:0] modes;
        logic [`NUM_CH-1:0] ovl_fault;
        logic [`NUM_CH-1:0] ot_fault;
        logic frame_error_flag;
        logic powerup;
        logic [`NUM_CH-1:0] driver_outputs;
        logic [`NUM_CH-1:0] diag_en;
    } ctrl_state_type;

    typedef struct packed {
        logic [`OVL_CNT_W-1:0] count;
        logic trip;
    } filter_state_type;

endpackage : drv_mode_pkg

// *** design/overload_filter.sv ***
`timescale 1ns/1ps
`include "drv_mode_consts.svh"

module overload_filter (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_sense,
    input wire logic i_driving,
    output logic o_trip
);
    import drv_mode_pkg::*;

    localparam logic [`OVL_CNT_W-1:0] LAST_CNT = `OVL_CNT_W'(`OVL_FILTER_CYC - 1);

    filter_state_type state_reg;
    filter_state_type state_next;

    // ==========================================================
    // spike filter: any gap in the overcurrent restarts the count
    always_comb begin
        state_next = state_reg;
        state_next.trip = 1'b0;
        if (i_sense && i_driving) begin
            if (state_reg.count == LAST_CNT) begin
                state_next.trip = 1'b1;
                state_next.count = '0;
            end else begin
                state_next.count = state_reg.count + `OVL_CNT_W'(1);
            end
        end else begin
            state_next.count = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_reg <= '0;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    assign o_trip = state_reg.trip;

    // ==========================================================
    // checks
    property p_trip_needs_sense;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(o_trip) |-> $past(i_sense) && $past(i_driving);
    endproperty
    a_trip_needs_sense: assert property (p_trip_needs_sense)
        else $error("overload trip without a sustained overcurrent");

    property p_spike_ignored;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_ce && !i_sense) |=> (state_reg.count == '0) && !o_trip;
    endproperty
    a_spike_ignored: assert property (p_spike_ignored)
        else $error("filter count survived a gap in overcurrent");

endmodule : overload_filter

// *** design/octal_driver_mode_control.sv ***
`timescale 1ns/1ps
`include "drv_mode_consts.svh"

// How it works
// - overcurrent held past the filter delay latches the channel off; spikes ignored.
// - overload works when switched on into a short or shorted while on.
// - host clears a channel fault with standby code; supply reset with limp low clears too.
// - each enable rising edge outside limp home resets every setting to defaults.
// - per channel two-bit mode: standby, parallel input, on, off.
// - after reset command bits are all ones, status zero, frame error flag set.
// - both supplies needed; in limp home only the analog supply reset acts.
// - every entry into global off keeps diagnostic current off until the first good frame.
// - outputs off in lockout; leaving it with limp high enters limp home.
// - all channels standby gives global standby, outputs and diagnostics off.
// - enable and limp low gives lowest quiescent state, outputs off.
// - in normal operation parallel pin n drives channels n and n+4.
// - a channel commanded off ignores its paired parallel pin.
// - faults during parallel drive persist until the host clears them.
// - limp home: channels 1-4 follow pins, channels 5-8 held off.
// - limp home ignores commands, still latches faults; only leaving limp home clears them.
// - leaving limp home resets everything, enters off or lowest quiescent state.
// - leaving limp home into global off sets the frame error flag.
// - analog reset forces lockout; with limp high fault information is kept.
// - power-up on enable rise or limp rise; limp rise wins over enable.
// - standby on one channel clears only that channel's faults.
// - command frame two bits per channel; status two bits per channel.
// - per-channel overtemperature latches only that channel off.
module octal_driver_mode_control (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input drv_mode_pkg::pin_bundle_type i_pins,
    input drv_mode_pkg::cmd_frame_type i_cmd,
    output logic [`NUM_CH-1:0] o_driver_outputs,
    output logic [`NUM_CH-1:0] o_diag_current_en,
    output logic [`STATUS_W-1:0] o_status,
    output logic o_frame_error_flag,
    output drv_mode_pkg::op_state_type o_op_state,
    output logic o_global_standby,
    output logic o_lowest_quiescent_state
);
    import drv_mode_pkg::*;

    localparam ctrl_state_type CTRL_RESET = '{
        sync1: '0, sync2: '0, prev: '0,
        state: op_uvlo,
        modes: `MODES_RESET,
        ovl_fault: `FAULTS_RESET,
        ot_fault: `FAULTS_RESET,
        frame_error_flag: 1'b1,
        powerup: 1'b1,
        driver_outputs: '0,
        diag_en: '0
    };

    ctrl_state_type state_reg;
    ctrl_state_type state_next;
    pin_bundle_type pins;
    logic en_rise;
    logic limp_rise;
    logic supply_reset;
    logic [`NUM_CH-1:0] ovl_trip;
    logic [`NUM_CH-1:0] standby_sel;

    assign pins = state_reg.sync2;
    assign en_rise = pins.enable & ~state_reg.prev.enable;
    assign limp_rise = pins.limp_home_input & ~state_reg.prev.limp_home_input;
    // limp home masks the logic supply, never the analog one
    assign supply_reset = ~pins.analog_supply_ok | (~pins.logic_supply_ok & ~pins.limp_home_input);

    // ==========================================================
    // per-channel overload filters and status packing
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CH; ch++) begin : g_chan
            overload_filter overload_filter_i (
                .i_clk_sys(i_clk_sys),
                .i_reset_n(i_reset_n),
                .i_ce(i_ce),
                .i_sense(pins.overcurrent[ch]),
                .i_driving(state_reg.driver_outputs[ch]),
                .o_trip(ovl_trip[ch])
            );
            assign o_status[2*ch+`OVL_BIT] = state_reg.ovl_fault[ch];
            assign o_status[2*ch+`OT_BIT] = state_reg.ot_fault[ch];
            assign standby_sel[ch] = (i_cmd.modes[2*ch+:2] == `MODE_STANDBY);
        end
    endgenerate

    // ==========================================================
    // operating state, modes, faults
    always_comb begin
        state_next = state_reg;
        state_next.sync1 = i_pins;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
        case (state_reg.state)
            op_uvlo: begin
                state_next.modes = `MODES_RESET;
                state_next.frame_error_flag = 1'b1;
                state_next.powerup = 1'b1;
                if (!pins.limp_home_input) begin
                    state_next.ovl_fault = `FAULTS_RESET;
                    state_next.ot_fault = `FAULTS_RESET;
                end
                if (pins.limp_home_input) begin
                    state_next.state = op_limp;
                end else if (pins.enable) begin
                    state_next.state = op_global_off;
                end else begin
                    state_next.state = op_low_iq;
                end
            end
            op_low_iq: begin
                state_next.modes = `MODES_RESET;
                state_next.ovl_fault = `FAULTS_RESET;
                state_next.ot_fault = `FAULTS_RESET;
                if (pins.limp_home_input) begin
                    state_next.state = op_limp;
                end else if (en_rise) begin
                    state_next.state = op_global_off;
                    state_next.frame_error_flag = 1'b1;
                    state_next.powerup = 1'b1;
                end
            end
            op_global_off: begin
                if (limp_rise || pins.limp_home_input) begin
                    state_next.state = op_limp;
                end else if (!pins.enable) begin
                    state_next.state = op_low_iq;
                    state_next.modes = `MODES_RESET;
                    state_next.ovl_fault = `FAULTS_RESET;
                    state_next.ot_fault = `FAULTS_RESET;
                end else if (i_cmd.valid) begin
                    if (i_cmd.frame_ok) begin
                        state_next.modes = i_cmd.modes;
                        state_next.frame_error_flag = 1'b0;
                        state_next.powerup = 1'b0;
                        for (int i = 0; i < `NUM_CH; i++) begin
                            if (i_cmd.modes[2*i+:2] == `MODE_STANDBY) begin
                                state_next.ovl_fault[i] = 1'b0;
                                state_next.ot_fault[i] = 1'b0;
                            end
                        end
                    end else begin
                        state_next.frame_error_flag = 1'b1;
                    end
                end
            end
            op_limp: begin
                if (!pins.limp_home_input) begin
                    state_next.modes = `MODES_RESET;
                    state_next.ovl_fault = `FAULTS_RESET;
                    state_next.ot_fault = `FAULTS_RESET;
                    state_next.powerup = 1'b1;
                    if (pins.enable) begin
                        state_next.state = op_global_off;
                        state_next.frame_error_flag = 1'b1;
                    end else begin
                        state_next.state = op_low_iq;
                    end
                end
            end
            default: begin
                state_next.state = op_uvlo;
            end
        endcase

        // a fault event in the clearing cycle still latches
        if (state_reg.state == op_global_off || state_reg.state == op_limp) begin
            state_next.ovl_fault = state_next.ovl_fault | ovl_trip;
            state_next.ot_fault = state_next.ot_fault | pins.overtemp;
        end

        if (supply_reset) begin
            state_next.state = op_uvlo;
        end

        // drive is planned from the next state so outputs never lag a lockout
        for (int i = 0; i < `NUM_CH; i++) begin
            state_next.driver_outputs[i] = 1'b0;
            state_next.diag_en[i] = 1'b0;
            if (state_next.state == op_global_off) begin
                case (state_next.modes[2*i+:2])
                    `MODE_ON: state_next.driver_outputs[i] = 1'b1;
                    `MODE_PARALLEL: state_next.driver_outputs[i] = pins.par_in[i % `PAIR_CH];
                    `MODE_OFF: state_next.diag_en[i] = ~state_next.powerup;
                    default: state_next.driver_outputs[i] = 1'b0;
                endcase
            end else if (state_next.state == op_limp && i < `PAIR_CH) begin
                state_next.driver_outputs[i] = pins.par_in[i];
            end
        end
        state_next.driver_outputs = state_next.driver_outputs & ~(state_next.ovl_fault | state_next.ot_fault);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_reg <= CTRL_RESET;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign o_driver_outputs = state_reg.driver_outputs;
    assign o_diag_current_en = state_reg.diag_en;
    assign o_frame_error_flag = state_reg.frame_error_flag;
    assign o_op_state = state_reg.state;
    assign o_global_standby = (state_reg.state == op_global_off) && (state_reg.modes == '0);
    assign o_lowest_quiescent_state = (state_reg.state == op_low_iq);

    // ==========================================================
    // checks
    property p_uvlo_off;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (state_reg.state == op_uvlo) |-> (o_driver_outputs == '0) && (o_diag_current_en == '0);
    endproperty
    a_uvlo_off: assert property (p_uvlo_off)
        else $error("outputs active in undervoltage lockout");

    property p_low_iq_off;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_lowest_quiescent_state |-> (o_driver_outputs == '0) && (o_diag_current_en == '0);
    endproperty
    a_low_iq_off: assert property (p_low_iq_off)
        else $error("outputs active in lowest quiescent state");

    property p_limp_upper_off;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (state_reg.state == op_limp) |-> (o_driver_outputs[`NUM_CH-1:`PAIR_CH] == '0);
    endproperty
    a_limp_upper_off: assert property (p_limp_upper_off)
        else $error("upper channels driven in limp home");

    property p_fault_forces_off;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        ((state_reg.ovl_fault | state_reg.ot_fault) & o_driver_outputs) == '0;
    endproperty
    a_fault_forces_off: assert property (p_fault_forces_off)
        else $error("faulted channel still driving");

    property p_global_standby;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_global_standby |-> (o_driver_outputs == '0) && (o_diag_current_en == '0);
    endproperty
    a_global_standby: assert property (p_global_standby)
        else $error("global standby with outputs or diagnostics on");

    property p_limp_ignores_cmd;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_ce && i_cmd.valid && state_reg.state == op_limp && pins.limp_home_input && !supply_reset)
            |=> $stable(state_reg.modes);
    endproperty
    a_limp_ignores_cmd: assert property (p_limp_ignores_cmd)
        else $error("command accepted in limp home");

    property p_bad_frame_kept;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_ce && i_cmd.valid && !i_cmd.frame_ok && state_reg.state == op_global_off && pins.enable
            && !pins.limp_home_input && !supply_reset)
            |=> $stable(state_reg.modes) && o_frame_error_flag;
    endproperty
    a_bad_frame_kept: assert property (p_bad_frame_kept)
        else $error("rejected frame changed the modes");

    sequence s_limp_exit;
        (state_reg.state == op_limp) ##1 (state_reg.state == op_global_off);
    endsequence
    property p_limp_exit_flag;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        s_limp_exit |-> o_frame_error_flag && (o_diag_current_en == '0) && (state_reg.modes == `MODES_RESET);
    endproperty
    a_limp_exit_flag: assert property (p_limp_exit_flag)
        else $error("limp home exit without flag or defaults");

    property p_standby_clears_one;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_ce && i_cmd.valid && i_cmd.frame_ok && state_reg.state == op_global_off && pins.enable
            && !pins.limp_home_input && !supply_reset && standby_sel[0]
            && !ovl_trip[0] && !pins.overtemp[0])
            |=> (o_status[1:0] == 2'h0)
            && (state_reg.ovl_fault[`NUM_CH-1:1]
            == (($past(state_reg.ovl_fault[`NUM_CH-1:1]) & ~$past(standby_sel[`NUM_CH-1:1]))
            | $past(ovl_trip[`NUM_CH-1:1])));
    endproperty
    a_standby_clears_one: assert property (p_standby_clears_one)
        else $error("standby did not clear exactly its own channel");

    property p_enable_rise_defaults;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_ce && state_reg.state == op_low_iq && en_rise && !pins.limp_home_input && !supply_reset)
            |=> (state_reg.state == op_global_off) && (state_reg.modes == `MODES_RESET) && o_frame_error_flag
            && (o_diag_current_en == '0) && (o_status == '0);
    endproperty
    a_enable_rise_defaults: assert property (p_enable_rise_defaults)
        else $error("enable rising edge did not restore defaults");

    // lockout with limp high must not lose what the host has yet to read
    property p_uvlo_keeps_faults;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_ce && state_reg.state == op_uvlo && pins.limp_home_input) |=> $stable(o_status);
    endproperty
    a_uvlo_keeps_faults: assert property (p_uvlo_keeps_faults)
        else $error("fault status lost in lockout with limp home high");

endmodule : octal_driver_mode_control

// *** verification/host_model.sv ***
`timescale 1ns/1ps
`include "drv_mode_consts.svh"

module host_model (
    input wire logic i_clk_sys,
    output drv_mode_pkg::cmd_frame_type o_cmd
);
    import drv_mode_pkg::*;

    initial begin
        o_cmd = '0;
    end

    // ==========================================================
    // frame hand-over
    // one checked frame per call, launched just after a falling edge
    task automatic send_frame(input logic [2*`NUM_CH-1:0] modes, input logic ok);
        @(negedge i_clk_sys);
        o_cmd.valid = 1'b1;
        o_cmd.frame_ok = ok;
        o_cmd.modes = modes;
        @(negedge i_clk_sys);
        o_cmd.valid = 1'b0;
        // lines are not held after the frame, so show a changed value
        o_cmd.modes = ~modes;
    endtask : send_frame
endmodule : host_model

// *** verification/octal_driver_mode_control_tb.sv ***
`timescale 1ns/1ps
`include "drv_mode_consts.svh"

module octal_driver_mode_control_tb;
    import drv_mode_pkg::*;

    // long enough for the two overload runs plus all pin settling
    localparam int TIMEOUT_CYC = 6000;

    logic clk_sys;
    logic reset_n;
    logic ce;
    pin_bundle_type pins;
    cmd_frame_type cmd;
    logic [`NUM_CH-1:0] outs;
    logic [`NUM_CH-1:0] diag;
    logic [`STATUS_W-1:0] status;
    logic flag;
    op_state_type op_state;
    logic gstandby;
    logic low_q;
    int error_cnt;
    int checked;
    int cycles;

    // ==========================================================
    // design and host
    octal_driver_mode_control octal_driver_mode_control_i (
        .i_clk_sys(clk_sys),
        .i_reset_n(reset_n),
        .i_ce(ce),
        .i_pins(pins),
        .i_cmd(cmd),
        .o_driver_outputs(outs),
        .o_diag_current_en(diag),
        .o_status(status),
        .o_frame_error_flag(flag),
        .o_op_state(op_state),
        .o_global_standby(gstandby),
        .o_lowest_quiescent_state(low_q)
    );

    host_model host_model_i (
        .i_clk_sys(clk_sys),
        .o_cmd(cmd)
    );

    // ==========================================================
    // clock and timeout
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        cycles = 0;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == TIMEOUT_CYC) begin
            error_cnt++;
            final_report();
        end
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // two sync flops plus the output register, one spare edge
    task automatic settle();
        repeat (4) @(negedge clk_sys);
    endtask : settle

    task automatic send(input logic [15:0] modes);
        host_model_i.send_frame(modes, 1'b1);
    endtask : send

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // ==========================================================
    // scenarios
    task automatic test_reset();
        check(16'(op_state), 16'(op_uvlo));
        check(16'(flag), 16'h0001);
        check(status, 16'h0000);
        check(16'(outs), 16'h0000);
        $display("test reset done");
    endtask : test_reset

    task automatic test_powerup();
        pins.logic_supply_ok = 1'b1;
        pins.analog_supply_ok = 1'b1;
        pins.enable = 1'b1;
        settle();
        check(16'(op_state), 16'(op_global_off));
        check(16'(flag), 16'h0001);
        check(16'(diag), 16'h0000);
        check(16'(outs), 16'h0000);
        $display("test powerup done");
    endtask : test_powerup

    task automatic test_modes();
        send({8{`MODE_ON}});
        check(16'(outs), 16'h00FF);
        check(16'(flag), 16'h0000);
        send({8{`MODE_OFF}});
        check(16'(outs), 16'h0000);
        check(16'(diag), 16'h00FF);
        pins.par_in = 4'h5;
        settle();
        send({8{`MODE_PARALLEL}});
        check(16'(outs), 16'h0055);
        send({8{`MODE_STANDBY}});
        check(16'(outs), 16'h0000);
        check(16'(diag), 16'h0000);
        check(16'(gstandby), 16'h0001);
        host_model_i.send_frame({8{`MODE_ON}}, 1'b0);
        check(16'(outs), 16'h0000);
        check(16'(flag), 16'h0001);
        $display("test modes done");
    endtask : test_modes

    task automatic test_pairs();
        pins.par_in = 4'hF;
        settle();
        send({{4{`MODE_OFF}}, {4{`MODE_PARALLEL}}});
        check(16'(outs), 16'h000F);
        pins.par_in = 4'h0;
        settle();
        check(16'(outs), 16'h0000);
        $display("test pairs done");
    endtask : test_pairs

    // a frame sent while the clock enable is low must be missed; a pin change then is only taken once it is high again
    task automatic test_freeze();
        ce = 1'b0;
        pins.par_in = 4'hF;
        send({8{`MODE_ON}});
        settle();
        check(16'(outs), 16'h0000);
        ce = 1'b1;
        settle();
        check(16'(outs), 16'h000F);
        pins.par_in = 4'h0;
        $display("test freeze done");
    endtask : test_freeze

    task automatic test_overload();
        send({{7{`MODE_OFF}}, `MODE_ON});
        pins.overcurrent[0] = 1'b1;
        repeat (100) @(negedge clk_sys);
        pins.overcurrent[0] = 1'b0;
        settle();
        check(16'(outs), 16'h0001);
        check(status, 16'h0000);
        pins.overcurrent[0] = 1'b1;
        repeat (800) @(negedge clk_sys);
        check(16'(outs), 16'h0000);
        check(status, 16'h0001);
        pins.overcurrent[0] = 1'b0;
        pins.overtemp[2] = 1'b1;
        settle();
        pins.overtemp[2] = 1'b0;
        settle();
        check(status, 16'h0021);
        check(16'(outs), 16'h0000);
        send({{7{`MODE_OFF}}, `MODE_STANDBY});
        check(status, 16'h0020);
        pins.overcurrent[1] = 1'b1;
        settle();
        send({{6{`MODE_OFF}}, `MODE_ON, `MODE_STANDBY});
        repeat (800) @(negedge clk_sys);
        check(status, 16'h0024);
        check(16'(outs), 16'h0000);
        pins.overcurrent[1] = 1'b0;
        settle();
        $display("test overload done");
    endtask : test_overload

    task automatic test_limp();
        pins.par_in = 4'hA;
        pins.limp_home_input = 1'b1;
        settle();
        check(16'(op_state), 16'(op_limp));
        // channel 1 still carries its latched overload, so only channel 3 drives
        check(16'(outs), 16'h0008);
        check(status, 16'h0024);
        send({8{`MODE_ON}});
        check(16'(outs), 16'h0008);
        pins.logic_supply_ok = 1'b0;
        settle();
        check(16'(op_state), 16'(op_limp));
        pins.logic_supply_ok = 1'b1;
        pins.limp_home_input = 1'b0;
        settle();
        check(16'(op_state), 16'(op_global_off));
        check(16'(flag), 16'h0001);
        check(16'(outs), 16'h0000);
        check(16'(diag), 16'h0000);
        check(status, 16'h0000);
        pins.par_in = 4'h0;
        $display("test limp done");
    endtask : test_limp

    task automatic test_enable();
        send({8{`MODE_ON}});
        pins.enable = 1'b0;
        settle();
        check(16'(op_state), 16'(op_low_iq));
        check(16'(low_q), 16'h0001);
        check(16'(outs), 16'h0000);
        pins.enable = 1'b1;
        settle();
        check(16'(op_state), 16'(op_global_off));
        check(16'(flag), 16'h0001);
        check(16'(outs), 16'h0000);
        $display("test enable done");
    endtask : test_enable

    task automatic test_supply();
        send({8{`MODE_ON}});
        check(16'(outs), 16'h00FF);
        pins.analog_supply_ok = 1'b0;
        settle();
        check(16'(op_state), 16'(op_uvlo));
        check(16'(outs), 16'h0000);
        pins.limp_home_input = 1'b1;
        pins.analog_supply_ok = 1'b1;
        settle();
        check(16'(op_state), 16'(op_limp));
        $display("test supply done");
    endtask : test_supply

    // ==========================================================
    // main sequence
    initial begin
        error_cnt = 0;
        checked = 0;
        reset_n = 1'b0;
        ce = 1'b1;
        pins = '0;
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        settle();
        test_reset();
        test_powerup();
        test_modes();
        test_pairs();
        test_freeze();
        test_overload();
        test_limp();
        test_enable();
        test_supply();
        final_report();
    end
endmodule : octal_driver_mode_control_tb
